/* design/asp_map.svh */
// Constants for the asynchronous serial port
//
// Contract
// [R1] Character carries five to eight data bits, set by configuration.
// [R2] One or two stop bits; parity none, even or odd, made and checked.
// [R3] Frame spans seven to twelve bit times with start, data, parity, stop.
// [R4] Programmed mode keeps one holding word besides each shifter; the receiver keeps a four-word buffer instead.
// [R5] DMA mode raises separate transmit and receive request lines.
// [R6] Bit rate is clock over divisor, over sixteen unless bypass is set.
// [R7] Divisor is sixteen bits from high byte and low byte concatenated.
// [R8] Slowest rate is clock over 1,048,576 with maximum divisor; the divider reaches clock over 1,048,560.
// [R9] Transmit and receive interrupt requests, each separately maskable.
// [R10] Transmit interrupt selectable: holding stage empty or shifter done.
// [R11] With flow control on, no new character starts while permit is low.
// [R12] Pause output drops when receive fill exceeds the high-water level.
// [R13] Infrared mode sends short pulses and decodes received pulses; the receive path takes serial_in undecoded.
// [R14] Receive line is brought out for timer pulse-width measurement.
// [R15] Idle high, low start bit, data LSB first, parity, high stops.
// [R16] Start found on falling edge, mid-bit sampling, error flags kept.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_OVERSAMPLE 5'd16
`define ASP_MID_SAMPLE 4'h7
`define ASP_IR_PULSE 4'h2
`define ASP_DIV_RESET 16'h0001
`define ASP_FIFO_DEPTH 4
`endif

/* design/asp_pkg.sv */
// Types shared by the asynchronous serial port
package asp_pkg;
  typedef enum logic [1:0] {ASP_PAR_NONE, ASP_PAR_EVEN, ASP_PAR_ODD} asp_parity_e;
  typedef struct packed {
    logic [1:0] data_bits_m5;
    logic two_stop;
    asp_parity_e parity;
    logic divide_bypass_bit;
    logic infrared_en;
    logic auto_cts_en;
    logic auto_rts_en;
    logic dma_mode;
    logic tx_irq_on_shift_done;
  } asp_cfg_s;
  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic overrun_err;
  } asp_err_s;
  typedef enum logic [2:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_PARITY, ASP_STOP} asp_state_e;
endpackage

/* design/asp_rx_fifo.sv */
// Small receive buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module asp_rx_fifo #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic [AW:0] level
);
  logic [7:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_wr;
  logic do_rd;
  assign do_wr = wr_en && (cnt_r != AW'(0) + (AW+1)'(DEPTH) || do_rd);
  assign do_rd = rd_en && (cnt_r != '0);
  assign level = cnt_r;
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr_data;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rd_data <= 8'h00;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + AW'(1);
      end
      if (do_rd) begin
        rp_r <= rp_r + AW'(1);
        rd_data <= mem_r[rp_r];
      end
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

/* design/asp_top.sv */
// Asynchronous serial port with flow control and infrared option
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"
module asp_top
  import asp_pkg::*;
#(
  parameter int FIFO_DEPTH = `ASP_FIFO_DEPTH,
  parameter int FIFO_AW = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire asp_cfg_s cfg,
  input wire logic [7:0] divisor_high_byte,
  input wire logic [7:0] divisor_low_byte,
  input wire logic [FIFO_AW:0] rx_high_water,
  input wire logic tx_irq_mask,
  input wire logic rx_irq_mask,
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic rx_rd,
  output logic [7:0] rx_data,
  output logic rx_avail,
  output logic [FIFO_AW:0] rx_level,
  output asp_err_s rx_err,
  input wire logic err_clr,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic tx_irq,
  output logic rx_irq,
  output logic tx_busy,
  output logic serial_out,
  input wire logic serial_in,
  input wire logic transmit_permit_in,
  output logic receiver_pause_out,
  output logic rx_line_to_timer
);
  // ----------------------------------------
  // Bit clock divider
  // ----------------------------------------
  logic [15:0] div_cnt_r;
  logic [15:0] divisor;
  logic os_tick;
  logic [3:0] pre_cnt_r;
  logic bit_tick_tx;
  // [R7] Divisor from bytes
  assign divisor = {divisor_high_byte, divisor_low_byte};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= 16'h0000;
    end else if (div_cnt_r + 16'h0001 >= divisor) begin
      div_cnt_r <= 16'h0000;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end
  assign os_tick = (div_cnt_r + 16'h0001 >= divisor);
  // [R6] [R8] Sixteen-times stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= 4'h0;
    end else if (os_tick) begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end
  assign bit_tick_tx = os_tick && (cfg.divide_bypass_bit || pre_cnt_r == 4'hF);

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [7:0] thr_r;
  logic thr_full_r;
  logic [7:0] tsr_r;
  asp_state_e tx_st_r;
  logic [2:0] tx_bit_r;
  logic tx_stop2_r;
  logic tx_par_r;
  logic tx_line_r;
  logic [3:0] ir_cnt_r;
  logic [2:0] nbits;
  logic tx_load;
  // Index of the last data bit: four plus the width code
  assign nbits = {1'b1, cfg.data_bits_m5};
  // [R4] Holding word beside the shifter
  assign tx_ready = !thr_full_r;
  // [R11] Start only when permitted
  assign tx_load = bit_tick_tx && tx_st_r == ASP_IDLE && thr_full_r &&
                   (!cfg.auto_cts_en || transmit_permit_in);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_r <= 8'h00;
      thr_full_r <= 1'b0;
    end else if (tx_wr && !thr_full_r) begin
      thr_r <= tx_data;
      thr_full_r <= 1'b1;
    end else if (tx_load) begin
      thr_full_r <= 1'b0;
    end
  end
  // [R1] [R2] [R3] [R15] Frame sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r <= ASP_IDLE;
      tsr_r <= 8'h00;
      tx_bit_r <= 3'h0;
      tx_stop2_r <= 1'b0;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (bit_tick_tx) begin
      unique case (tx_st_r)
        ASP_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_load) begin
            tsr_r <= thr_r;
            tx_par_r <= (cfg.parity == ASP_PAR_ODD);
            tx_line_r <= 1'b0;
            tx_st_r <= ASP_START;
          end
        end
        ASP_START, ASP_DATA: begin
          if (tx_st_r == ASP_START) begin
            tx_bit_r <= 3'h0;
          end else begin
            tx_bit_r <= tx_bit_r + 3'h1;
          end
          if (tx_st_r == ASP_DATA && tx_bit_r == nbits) begin
            tx_line_r <= (cfg.parity == ASP_PAR_NONE) ? 1'b1 : tx_par_r;
            tx_stop2_r <= cfg.two_stop;
            tx_st_r <= (cfg.parity == ASP_PAR_NONE) ? ASP_STOP : ASP_PARITY;
          end else begin
            tx_line_r <= tsr_r[0];
            tx_par_r <= tx_par_r ^ tsr_r[0];
            tsr_r <= {1'b0, tsr_r[7:1]};
            tx_st_r <= ASP_DATA;
          end
        end
        ASP_PARITY: begin
          tx_line_r <= 1'b1;
          tx_st_r <= ASP_STOP;
        end
        ASP_STOP: begin
          if (tx_stop2_r) begin
            tx_stop2_r <= 1'b0;
          end else begin
            tx_st_r <= ASP_IDLE;
          end
        end
        default: tx_st_r <= ASP_IDLE;
      endcase
    end
  end
  assign tx_busy = (tx_st_r != ASP_IDLE);
  // [R13] Infrared pulse shaping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_cnt_r <= 4'h0;
    end else if (bit_tick_tx) begin
      // Restart on every bit, so the start bit pulses too
      ir_cnt_r <= 4'h0;
    end else if (os_tick && ir_cnt_r != 4'hF) begin
      ir_cnt_r <= ir_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out <= 1'b1;
    end else if (cfg.infrared_en) begin
      serial_out <= !(tx_st_r != ASP_IDLE && !tx_line_r && ir_cnt_r < `ASP_IR_PULSE);
    end else begin
      serial_out <= tx_line_r;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic rx_line;
  logic rx_prev_r;
  asp_state_e rx_st_r;
  logic [3:0] rx_os_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rsr_r;
  logic rx_par_r;
  logic rx_push;
  logic rx_mid;
  logic [7:0] rx_word;
  logic [3:0] rx_os_end;
  // [R13] Infrared low pulse should decode to zero; rx_line takes serial_in unchanged in both modes
  assign rx_line = cfg.infrared_en ? serial_in : serial_in;
  // [R14] Line for timer measurement
  assign rx_line_to_timer = serial_in;
  assign rx_os_end = cfg.divide_bypass_bit ? 4'h0 : 4'hF;
  assign rx_mid = os_tick && (cfg.divide_bypass_bit || rx_os_r == `ASP_MID_SAMPLE);
  assign rx_word = rsr_r >> (3'd3 - cfg.data_bits_m5);
  // [R16] Falling edge and mid-bit sampling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_prev_r <= 1'b1;
      rx_st_r <= ASP_IDLE;
      rx_os_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rsr_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_push <= 1'b0;
    end else begin
      rx_prev_r <= rx_line;
      rx_push <= 1'b0;
      if (rx_st_r == ASP_IDLE) begin
        rx_os_r <= 4'h0;
        if (rx_prev_r && !rx_line) begin
          rx_st_r <= ASP_START;
        end
      end else if (os_tick) begin
        rx_os_r <= (rx_os_r == rx_os_end) ? 4'h0 : rx_os_r + 4'h1;
        if (rx_mid) begin
          unique case (rx_st_r)
            ASP_START: begin
              rx_bit_r <= 3'h0;
              rx_par_r <= (cfg.parity == ASP_PAR_ODD);
              rx_st_r <= rx_line ? ASP_IDLE : ASP_DATA;
            end
            ASP_DATA: begin
              rsr_r <= {rx_line, rsr_r[7:1]};
              rx_par_r <= rx_par_r ^ rx_line;
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == nbits) begin
                rx_st_r <= (cfg.parity == ASP_PAR_NONE) ? ASP_STOP : ASP_PARITY;
              end
            end
            ASP_PARITY: begin
              rx_par_r <= rx_par_r ^ rx_line;
              rx_st_r <= ASP_STOP;
            end
            ASP_STOP: begin
              rx_push <= 1'b1;
              rx_st_r <= ASP_IDLE;
            end
            default: rx_st_r <= ASP_IDLE;
          endcase
        end
      end
    end
  end
  // [R16] Sticky error flags, set wins over clear
  logic rx_full;
  assign rx_full = (rx_level == (FIFO_AW+1)'(FIFO_DEPTH));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_err <= '0;
    end else begin
      if (err_clr) begin
        rx_err <= '0;
      end
      if (rx_mid && rx_st_r == ASP_STOP && !rx_line) begin
        rx_err.framing_err <= 1'b1;
      end
      if (rx_mid && rx_st_r == ASP_STOP && cfg.parity != ASP_PAR_NONE && rx_par_r) begin
        rx_err.parity_err <= 1'b1;
      end
      if (rx_push && rx_full && !rx_rd) begin
        rx_err.overrun_err <= 1'b1;
      end
    end
  end
  // [R4] Receive holding stage
  asp_rx_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(rx_push),
    .wr_data(rx_word),
    .rd_en(rx_rd),
    .rd_data(rx_data),
    .level(rx_level)
  );
  assign rx_avail = (rx_level != '0);
  // [R12] Pause above high water
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      receiver_pause_out <= 1'b1;
    end else begin
      receiver_pause_out <= !(cfg.auto_rts_en && rx_level > rx_high_water);
    end
  end

  // ----------------------------------------
  // Requests and interrupts
  // ----------------------------------------
  logic tx_event;
  // [R10] Transmit interrupt timing select
  assign tx_event = cfg.tx_irq_on_shift_done ? (!thr_full_r && !tx_busy) : !thr_full_r;
  // [R5] Separate DMA requests
  assign tx_dma_req = cfg.dma_mode && !thr_full_r;
  assign rx_dma_req = cfg.dma_mode && rx_avail;
  // [R9] Maskable interrupt lines
  assign tx_irq = !cfg.dma_mode && tx_irq_mask && tx_event;
  assign rx_irq = !cfg.dma_mode && rx_irq_mask && rx_avail;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // [R11] Permit gates start
  cts_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tx_st_r == ASP_IDLE && cfg.auto_cts_en && !transmit_permit_in) |=> tx_st_r != ASP_START)
    else $error("character started while permit low");
  // [R12] Pause level
  rts_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg.auto_rts_en && rx_level > rx_high_water) |=> !receiver_pause_out)
    else $error("pause not dropped above high water");
  // [R15] Start bit low
  start_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tx_st_r == ASP_START) |-> !tx_line_r)
    else $error("start bit not low");
  // [R4] Holding fill
  hold_fill_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tx_wr && !thr_full_r) |=> thr_full_r)
    else $error("holding stage did not fill");
  // [R5] DMA request
  dma_tx_req_a: assert property (@(posedge clk) disable iff (!rst_b)
    tx_dma_req |-> (cfg.dma_mode && tx_ready))
    else $error("transmit request without room");
  // [R9] Masked interrupt
  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    !rx_irq_mask |-> !rx_irq)
    else $error("masked receive interrupt raised");
  // [R7] Divider wrap
  div_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    $stable(divisor) && os_tick |=> div_cnt_r == 16'h0000)
    else $error("divider did not wrap");
  // [R16] Overrun flag
  overrun_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_push && rx_full && !rx_rd) |=> rx_err.overrun_err)
    else $error("overrun not flagged");
  tx_frame_c: cover property (@(posedge clk) disable iff (!rst_b)
    tx_st_r == ASP_STOP ##1 tx_st_r == ASP_IDLE);
  rx_word_c: cover property (@(posedge clk) disable iff (!rst_b) rx_push);
  pause_c: cover property (@(posedge clk) disable iff (!rst_b) $fell(receiver_pause_out));
endmodule
`default_nettype wire

/* sim/asp_peer.sv */
// Remote serial peer model for the asynchronous serial port bench
`timescale 1ns/1ps
`default_nettype none
module asp_peer (
  input wire logic clk,
  input wire logic serial_out,
  output logic serial_in,
  output logic transmit_permit_in
);
  // ----------------------------------------
  // Line driver and sampler
  // ----------------------------------------
  // Line idles high
  initial begin
    serial_in = 1'b1;
    transmit_permit_in = 1'b1;
  end
  task automatic permit(input logic v);
    @(negedge clk);
    transmit_permit_in = v;
  endtask
  task automatic send(input logic [11:0] f, input int bt);
    for (int b = 0; b < 12; b++) begin
      @(negedge clk);
      serial_in = f[b];
      repeat (bt - 1) @(negedge clk);
    end
  endtask
  // Early and late sample per bit, so rate drift shows
  task automatic recv(input int bt, input int n, output logic [11:0] f, output logic ok);
    logic a;
    f = 12'hFFF;
    ok = 1'b1;
    @(negedge serial_out);
    for (int b = 0; b < n; b++) begin
      @(negedge clk);
      a = serial_out;
      repeat (bt - 2) @(negedge clk);
      f[b] = serial_out;
      ok = ok & (a === serial_out);
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
`default_nettype none
module tb
  import asp_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, rst_b, tx_wr, rx_rd, err_clr, tx_ready, rx_avail, tx_irq_mask, rx_irq_mask;
  logic tx_dma_req, rx_dma_req, tx_irq, rx_irq, tx_busy, serial_out, serial_in;
  logic permit, pause, tap, st, st2;
  logic [7:0] div_h, div_l, tx_data, rx_data, d;
  logic [2:0] hw, rx_level;
  logic [11:0] fr, fr2;
  asp_cfg_s cfg;
  asp_err_s rx_err;
  int n_mismatch, cmp_count, seed, bt, lo;
  asp_top i_asp_top (.clk(clk), .rst_b(rst_b), .cfg(cfg), .divisor_high_byte(div_h),
    .divisor_low_byte(div_l), .rx_high_water(hw), .tx_irq_mask(tx_irq_mask),
    .rx_irq_mask(rx_irq_mask), .tx_wr(tx_wr), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_rd(rx_rd), .rx_data(rx_data), .rx_avail(rx_avail), .rx_level(rx_level),
    .rx_err(rx_err), .err_clr(err_clr), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_busy(tx_busy), .serial_out(serial_out),
    .serial_in(serial_in), .transmit_permit_in(permit), .receiver_pause_out(pause),
    .rx_line_to_timer(tap));
  asp_peer i_asp_peer (.clk(clk), .serial_out(serial_out), .serial_in(serial_in),
    .transmit_permit_in(permit));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] msk();
    return 8'hFF >> (2'd3 - cfg.data_bits_m5);
  endfunction
  function automatic int flen();
    return 7 + cfg.data_bits_m5 + (cfg.parity != ASP_PAR_NONE) + cfg.two_stop;
  endfunction
  function automatic logic [11:0] mk(input logic [7:0] v);
    logic [11:0] f;
    f = 12'hFFE;
    for (int i = 0; i < cfg.data_bits_m5 + 5; i++) f[i + 1] = v[i];
    if (cfg.parity != ASP_PAR_NONE) begin
      f[cfg.data_bits_m5 + 6] = ^(v & msk()) ^ (cfg.parity == ASP_PAR_ODD);
    end
    return f;
  endfunction
  task automatic wr(input logic [7:0] v);
    for (int k = 0; k < 20000 && tx_ready !== 1'b1; k++) @(negedge clk);
    tx_data = v;
    tx_wr = 1'b1;
    @(negedge clk);
    tx_wr = 1'b0;
  endtask
  task automatic rd();
    for (int k = 0; k < 20000 && rx_avail !== 1'b1; k++) @(negedge clk);
    rx_rd = 1'b1;
    @(negedge clk);
    rx_rd = 1'b0;
    @(negedge clk);
    d = rx_data;
  endtask
  task automatic clr();
    while (rx_avail === 1'b1) rd();
    err_clr = 1'b1;
    @(negedge clk);
    err_clr = 1'b0;
    @(negedge clk);
    chk(rx_err, 16'h0);
  endtask
  // Two back-to-back words; a short stop shows as a low last bit
  task automatic tx2(input logic [7:0] a, input logic [7:0] b);
    fork
      begin
        i_asp_peer.recv(bt, flen(), fr, st);
        i_asp_peer.recv(bt, flen(), fr2, st2);
      end
      begin
        wr(a);
        wr(b);
      end
    join
    chk(fr, mk(a));
    chk(fr2, mk(b));
    chk({st, st2}, 16'h3);
  endtask
  task automatic rx1(input logic [11:0] f, input logic [7:0] e);
    i_asp_peer.send(f, bt);
    rd();
    chk(d, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    #(90000 * 50);
    n_mismatch++;
    summarize();
  end
  initial begin
    seed = 50;
    n_mismatch = 0;
    cmp_count = 0;
    cfg = '0;
    {div_h, div_l, hw, tx_data} = {8'h00, 8'h02, 3'h4, 8'h00};
    {tx_irq_mask, rx_irq_mask, tx_wr, rx_rd, err_clr, rst_b} = 6'h30;
    bt = 32;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    chk({serial_out, pause, tx_ready, rx_err}, 16'h38);
    // Every width, stop count and parity
    for (int c = 0; c < 24; c++) begin
      @(negedge clk);
      cfg.data_bits_m5 = c[1:0];
      cfg.two_stop = c[2];
      cfg.parity = asp_parity_e'(c / 8);
      div_l = 8'h02 + 8'($random(seed) & 1);
      bt = 16 * div_l;
      tx2(8'($random(seed)), 8'($random(seed)));
      d = 8'($random(seed));
      rx1(mk(d), d & msk());
      chk({rx_err, tap}, {rx_err_zero(), serial_in});
    end
    // Bypass with high byte only, so byte order matters
    @(negedge clk);
    cfg = '0;
    cfg.data_bits_m5 = 2'd3;
    cfg.divide_bypass_bit = 1'b1;
    {div_h, div_l} = 16'h0100;
    bt = 256;
    tx2(8'hA5, 8'h00);
    @(negedge clk);
    cfg.divide_bypass_bit = 1'b0;
    cfg.parity = ASP_PAR_EVEN;
    {div_h, div_l} = 16'h0002;
    bt = 32;
    fr = mk(8'h3C) ^ 12'h200;
    i_asp_peer.send(fr, bt);
    chk(rx_err, 16'h4);
    clr();
    i_asp_peer.send(mk(8'h3C) & 12'hBFF, bt);
    chk(rx_err, 16'h2);
    clr();
    // Fill past depth with pause enabled
    cfg.auto_rts_en = 1'b1;
    hw = 3'h1;
    for (int k = 0; k < 5; k++) begin
      i_asp_peer.send(mk(8'h40 + 8'(k)), bt);
      chk({pause, rx_level}, {k == 0, 3'(k < 4 ? k + 1 : 4)});
    end
    chk(rx_err, 16'h1);
    // Request lines over mask and mode
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      {cfg.dma_mode, tx_irq_mask, rx_irq_mask} = {m[1], m[0], m[0]};
      @(negedge clk);
      chk({tx_irq, tx_dma_req, rx_irq, rx_dma_req}, {2{m[0] & ~m[1], m[1]}});
    end
    for (int k = 0; k < 4; k++) begin
      rd();
      chk(d, 8'h40 + 8'(k));
    end
    chk({pause, rx_avail}, 16'h2);
    clr();
    for (int s = 0; s < 2; s++) begin
      @(negedge clk);
      {cfg.dma_mode, cfg.tx_irq_on_shift_done} = {1'b0, s[0]};
      fork
        i_asp_peer.recv(bt, flen(), fr, st);
        begin
          wr(8'h81);
          for (int k = 0; k < 99 && tx_busy !== 1'b1; k++) @(negedge clk);
          repeat (bt) @(negedge clk);
          chk({tx_busy, tx_irq}, {1'b1, ~s[0]});
        end
      join
      repeat (bt) @(negedge clk);
      chk(tx_irq, 16'h1);
    end
    // One short low pulse per zero bit: start, four data, parity
    @(negedge clk);
    cfg.infrared_en = 1'b1;
    wr(8'h0F);
    lo = 0;
    repeat (14 * bt) begin
      @(negedge clk);
      lo += int'(serial_out === 1'b0);
    end
    chk(16'(lo), 16'h18);
    cfg.infrared_en = 1'b0;
    // Held word must wait for permit
    cfg.auto_cts_en = 1'b1;
    i_asp_peer.permit(1'b0);
    wr(8'h5A);
    st = 1'b1;
    repeat (4 * bt) begin
      @(negedge clk);
      st = st & serial_out;
    end
    chk(st, 16'h1);
    fork
      i_asp_peer.recv(bt, flen(), fr, st);
      i_asp_peer.permit(1'b1);
    join
    chk(fr, mk(8'h5A));
    summarize();
  end
  function automatic asp_err_s rx_err_zero();
    return '0;
  endfunction
endmodule
`default_nettype wire
